// ### common/anab_pkg.sv
// Constants, field layout and helpers for the auto-negotiation ability block.
//
// Behaviour
// (R1) The advertised word goes out to the link partner as local abilities.
// (R2) Advertised next-page bit always reads 0 and ignores writes.
// (R3) State machine drives advertised acknowledge; software writes to it are ignored.
// (R4) Advertised remote-fault bit is read/write, resets to 0.
// (R5) Software writes 0 to the advertised reserved bits, ignores them on read.
// (R6) Advertised pause bit is read/write, resets to 0.
// (R7) Advertised T4 bit always reads 0 and ignores writes.
// (R8) Four advertised technology bits are read/write and reset to 1.
// (R9) Advertised selector is read/write and resets to 00001.
// (R10) Partner register holds received partner abilities; all fields read-only.
// (R11) Partner next-page bit shows the partner's next-page flag, resets 0.
// (R12) Partner acknowledge bit follows incoming bursts; software writes ignored.
// (R13) Partner remote-fault bit shows the partner's fault flag, resets 0.
// (R14) Partner reserved bits read 0; writes have no effect.
// (R15) Partner pause bit shows partner flow control support, resets 0.
// (R16) Partner technology bits show partner abilities, reset to 0.
// (R17) Partner selector holds the received selector, resets to 00000.
// (R18) Latched status remote fault sets after partner fault; clears on read/reset.
// (R19) Partner register loads only after a complete, consistent code word.
package anab_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned WORD_W = 16;

  // Register addresses on the management register port.
  localparam logic [4:0] ADDR_BASIC_STATUS = 5'h01;
  localparam logic [4:0] ADDR_ADVERTISE = 5'h04;
  localparam logic [4:0] ADDR_PARTNER = 5'h05;

  // Field positions shared by both ability words.
  localparam int unsigned NEXT_PAGE_BIT = 15;
  localparam int unsigned ACK_BIT = 14;
  localparam int unsigned REMOTE_FAULT_BIT = 13;
  localparam int unsigned PAUSE_BIT = 10;
  localparam int unsigned T4_BIT = 9;
  localparam int unsigned TECH_HI = 8;
  localparam int unsigned TECH_LO = 5;
  localparam int unsigned SEL_HI = 4;
  localparam int unsigned SEL_LO = 0;

  // Bits software may change in the advertised word: 13..10 and 8..0.
  localparam logic [15:0] ADV_WRITE_MASK = 16'h3dff;
  // Advertised reset: four technology bits set, selector 00001.
  localparam logic [15:0] ADV_RESET = 16'h01e1;
  // Partner word keeps everything except the two reserved bits.
  localparam logic [15:0] PARTNER_KEEP_MASK = 16'he7ff;
  localparam logic [15:0] PARTNER_RESET = 16'h0000;

  // Identical code words needed before the partner word is taken.
  localparam int unsigned MATCH_COUNT = 3;

  function automatic logic addr_hit(input logic [4:0] addr,
                                    input logic [4:0] reg_addr);
    addr_hit = (addr == reg_addr);
  endfunction

  // Merges stored advertised bits with the hardware-owned acknowledge.
  function automatic logic [15:0] adv_view(input logic [15:0] stored,
                                           input logic ack);
    logic [15:0] v;
    v = stored & ADV_WRITE_MASK;
    v[ACK_BIT] = ack;
    adv_view = v;
  endfunction

endpackage

// ### hw/lcw_match.sv
// Consistency filter for received link code words.
`timescale 1ns/1ps
module lcw_match
  import anab_pkg::*;
#(
  parameter int unsigned MATCHES = MATCH_COUNT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Received words from the burst receiver
  input wire logic word_valid,
  input wire logic [15:0] word,
  // Accepted word
  output logic load_q,
  output logic [15:0] word_q
);

  localparam int unsigned CNT_W = $clog2(MATCHES + 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_DONE = CNT_W'(MATCHES);

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [15:0] last_q, last_d;
  logic load_d;
  logic [15:0] word_d;

  // A single corrupted burst can never reach the register: the same word
  // must arrive MATCHES times in a row. Reload is blocked until it changes.
  always_comb begin
    cnt_d = cnt_q;
    last_d = last_q;
    load_d = 1'b0;
    word_d = word_q;
    if (word_valid) begin
      last_d = word;
      if (word != last_q || cnt_q == '0) begin
        cnt_d = CNT_ONE;
      end else if (cnt_q != CNT_DONE) begin
        cnt_d = cnt_q + CNT_ONE;
      end
      if (word == last_q && cnt_q == CNT_DONE - CNT_ONE) begin
        load_d = 1'b1; // see (R19)
        word_d = word;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      last_q <= PARTNER_RESET;
      load_q <= 1'b0;
      word_q <= PARTNER_RESET;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      last_q <= last_d;
      load_q <= load_d;
      word_q <= word_d;
    end
  end

  AST_LOAD_AFTER_MATCH: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && word_valid && (word != last_q) |=> !load_q) // see (R19)
    else $error("partner word accepted without a repeat");

endmodule

// ### hw/anab_regs.sv
// Advertised and partner auto-negotiation ability registers.
`timescale 1ns/1ps
module anab_regs
  import anab_pkg::*;
#(
  parameter int unsigned MATCHES = MATCH_COUNT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Management register port
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata_q,
  output logic mgmt_rvalid_q,
  // Auto-negotiation state machine
  input wire logic an_ack_set,
  input wire logic lcw_valid,
  input wire logic [15:0] lcw_word,
  output logic [15:0] adv_tx_q,
  output logic [15:0] partner_q,
  output logic partner_update_q,
  // Basic status support
  output logic remote_fault_latched_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Advertised abilities.

  logic [15:0] adv_q, adv_d;
  logic ack_q, ack_d;
  logic [15:0] adv_tx_d;
  logic adv_wr;

  assign adv_wr = mgmt_wr && addr_hit(mgmt_addr, ADDR_ADVERTISE);

  always_comb begin
    adv_d = adv_q;
    if (adv_wr) begin
      // Next page, acknowledge and T4 are masked off, so writes cannot move
      // them; the reserved pair is stored as written.
      adv_d = mgmt_wdata & ADV_WRITE_MASK; // see (R2) see (R4) see (R6)
    end
    ack_d = an_ack_set; // see (R3)
    adv_tx_d = adv_view(adv_q, ack_q); // see (R1) see (R7)
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      adv_q <= ADV_RESET; // see (R8) see (R9)
      ack_q <= 1'b0;
      adv_tx_q <= ADV_RESET;
    end else if (clk_en) begin
      adv_q <= adv_d;
      ack_q <= ack_d;
      adv_tx_q <= adv_tx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Partner abilities.

  logic lcw_load;
  logic [15:0] lcw_accepted;
  logic [15:0] partner_d;
  logic partner_update_d;

  lcw_match #(
    .MATCHES(MATCHES)
  ) u_match (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .word_valid(lcw_valid),
    .word(lcw_word),
    .load_q(lcw_load),
    .word_q(lcw_accepted)
  );

  // Management writes to this address are simply not decoded, so the
  // partner word only ever changes from the link side.
  always_comb begin
    partner_d = partner_q;
    partner_update_d = 1'b0;
    if (lcw_load) begin
      // Next page, ack, fault, pause, technology and selector come from the
      // received word; the reserved pair is forced to zero.
      partner_d = lcw_accepted & PARTNER_KEEP_MASK; // see (R10) see (R14)
      partner_update_d = 1'b1; // see (R11) see (R12) see (R13)
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      partner_q <= PARTNER_RESET; // see (R15) see (R16) see (R17)
      partner_update_q <= 1'b0;
    end else if (clk_en) begin
      partner_q <= partner_d;
      partner_update_q <= partner_update_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched remote fault for the basic status register.

  logic rfl_d;
  logic status_rd;

  assign status_rd = mgmt_rd && addr_hit(mgmt_addr, ADDR_BASIC_STATUS);

  // The set term is tested last so a fault present in the same cycle as the
  // status read survives; the read value already showed it as one.
  always_comb begin
    rfl_d = remote_fault_latched_q;
    if (status_rd) begin
      rfl_d = 1'b0;
    end
    if (partner_q[REMOTE_FAULT_BIT]) begin
      rfl_d = 1'b1; // see (R18)
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      remote_fault_latched_q <= 1'b0;
    end else if (clk_en) begin
      remote_fault_latched_q <= rfl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  logic [15:0] rdata_d;
  logic rvalid_d;

  // Only this block's two addresses answer; every other address is left to
  // the neighbouring register banks, which share the same port.
  always_comb begin
    rdata_d = mgmt_rdata_q;
    rvalid_d = 1'b0;
    if (mgmt_rd && addr_hit(mgmt_addr, ADDR_ADVERTISE)) begin
      rdata_d = adv_view(adv_q, ack_q); // see (R2) see (R3) see (R7)
      rvalid_d = 1'b1;
    end else if (mgmt_rd && addr_hit(mgmt_addr, ADDR_PARTNER)) begin
      rdata_d = partner_q; // see (R10)
      rvalid_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mgmt_rdata_q <= 16'h0000;
      mgmt_rvalid_q <= 1'b0;
    end else if (clk_en) begin
      mgmt_rdata_q <= rdata_d;
      mgmt_rvalid_q <= rvalid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_adv_read;
    clk_en && mgmt_rd && addr_hit(mgmt_addr, ADDR_ADVERTISE);
  endsequence

  sequence s_adv_write;
    clk_en && adv_wr;
  endsequence

  sequence s_ack_two_steps;
    clk_en && an_ack_set ##1 clk_en;
  endsequence

  AST_ADV_NP_ZERO: assert property (@(posedge clk) disable iff (!resetn) // see (R2)
    s_adv_read |=> mgmt_rvalid_q && !mgmt_rdata_q[NEXT_PAGE_BIT])
    else $error("advertised next page read as one");

  AST_ADV_T4_ZERO: assert property (@(posedge clk) disable iff (!resetn) // see (R7)
    s_adv_write ##1 s_adv_read |=> !mgmt_rdata_q[T4_BIT])
    else $error("advertised T4 bit took a write");

  AST_ACK_OUT: assert property (@(posedge clk) disable iff (!resetn) // see (R3)
    s_ack_two_steps |=> adv_tx_q[ACK_BIT])
    else $error("acknowledge not sent two cycles after request");

  AST_RF_WRITE: assert property (@(posedge clk) disable iff (!resetn) // see (R4)
    s_adv_write |=> adv_q[REMOTE_FAULT_BIT] ==
      $past(mgmt_wdata[REMOTE_FAULT_BIT]))
    else $error("advertised remote fault did not take write");

  AST_PAUSE_WRITE: assert property (@(posedge clk) disable iff (!resetn) // see (R6)
    s_adv_write ##1 clk_en |=>
      adv_tx_q[PAUSE_BIT] == $past(mgmt_wdata[PAUSE_BIT], 2))
    else $error("advertised pause not sent after write");

  AST_SEL_READ: assert property (@(posedge clk) disable iff (!resetn) // see (R9)
    s_adv_read |=> mgmt_rdata_q[SEL_HI:SEL_LO] == $past(adv_q[SEL_HI:SEL_LO]))
    else $error("selector read differs from stored value");

  AST_PARTNER_LOAD: assert property (@(posedge clk) disable iff (!resetn) // see (R10)
    clk_en && lcw_load |=> partner_update_q &&
      partner_q == ($past(lcw_accepted) & PARTNER_KEEP_MASK))
    else $error("partner word not loaded from accepted word");

  AST_PARTNER_HOLD: assert property (@(posedge clk) disable iff (!resetn) // see (R19)
    clk_en && !lcw_load |=> $stable(partner_q) && !partner_update_q)
    else $error("partner word changed without accepted word");

  AST_PARTNER_RSV: assert property (@(posedge clk) disable iff (!resetn) // see (R14)
    clk_en && mgmt_rd && addr_hit(mgmt_addr, ADDR_PARTNER) |=>
      mgmt_rdata_q[REMOTE_FAULT_BIT-1:PAUSE_BIT+1] == 2'b00)
    else $error("partner reserved bits read nonzero");

  AST_RFL_SET: assert property (@(posedge clk) disable iff (!resetn) // see (R18)
    clk_en && partner_q[REMOTE_FAULT_BIT] |=> remote_fault_latched_q)
    else $error("remote fault not latched");

  AST_RFL_CLEAR: assert property (@(posedge clk) disable iff (!resetn) // see (R18)
    clk_en && status_rd && !partner_q[REMOTE_FAULT_BIT] |=>
      !remote_fault_latched_q)
    else $error("latched remote fault not cleared by status read");

endmodule

// ### dv/anab_partner.sv
// Far-side model: code-word receiver and acknowledge source.
`timescale 1ns/1ps
module anab_partner (
  // Clock
  input wire logic clk,
  // Towards the ability registers
  output logic an_ack_set,
  output logic lcw_valid,
  output logic [15:0] lcw_word
);
  initial begin
    an_ack_set = 1'b0;
    lcw_valid = 1'b0;
    lcw_word = 16'h0000;
  end

  // Sends one word n times with gap idle cycles after each copy.
  // The word lines toggle when idle, so a stale value is never held.
  task automatic send(input logic [15:0] w, input int n, input int gap);
    repeat (n) begin
      @(posedge clk);
      lcw_valid <= 1'b1;
      lcw_word <= w;
      repeat (gap) begin
        @(posedge clk);
        lcw_valid <= 1'b0;
        lcw_word <= ~w;
      end
    end
    @(posedge clk);
    lcw_valid <= 1'b0;
    lcw_word <= ~w;
  endtask

  task automatic ack(input logic a);
    @(posedge clk);
    an_ack_set <= a;
  endtask
endmodule

// ### dv/anab_regs_tb.sv
// Self-checking bench for the auto-negotiation ability registers.
`timescale 1ns/1ps
module anab_regs_tb;
  import anab_pkg::*;
  localparam int unsigned M = 3;
  logic clk, resetn, clk_en, mgmt_wr, mgmt_rd, mgmt_rvalid_q;
  logic an_ack_set, lcw_valid, partner_update_q, rf_q;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata_q, adv_tx_q, partner_q, lcw_word, w;
  logic [31:0] rs = 32'h0000_c83f;
  logic [15:0] exp_q[$];
  int failures = 0;
  int n_compared = 0;
  int n_upd = 0;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  anab_regs #(.MATCHES(M)) uut (.clk(clk), .resetn(resetn),
    .clk_en(clk_en), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
    .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata_q(mgmt_rdata_q), .mgmt_rvalid_q(mgmt_rvalid_q),
    .an_ack_set(an_ack_set), .lcw_valid(lcw_valid), .lcw_word(lcw_word),
    .adv_tx_q(adv_tx_q), .partner_q(partner_q),
    .partner_update_q(partner_update_q), .remote_fault_latched_q(rf_q));

  anab_partner p (.clk(clk), .an_ack_set(an_ack_set),
    .lcw_valid(lcw_valid), .lcw_word(lcw_word));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[15:0];
  endfunction

  task automatic cmp(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    mgmt_wr <= 1'b1;
    mgmt_addr <= a;
    mgmt_wdata <= d;
    @(posedge clk);
    mgmt_wr <= 1'b0;
    mgmt_wdata <= ~d;
  endtask

  // Only reads that must be answered leave a note for the monitor.
  task automatic rd(input logic [4:0] a, input logic [15:0] e,
                    input logic ans);
    @(posedge clk);
    mgmt_rd <= 1'b1;
    mgmt_addr <= a;
    if (ans) exp_q.push_back(e);
    @(posedge clk);
    mgmt_rd <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // An answer with no note pending is itself a mismatch.
  always @(negedge clk) begin
    if (partner_update_q === 1'b1) n_upd++;
    if (mgmt_rvalid_q === 1'b1) begin
      if (exp_q.size() == 0) cmp("unexpected answer", 16'h0000, 16'hffff);
      else cmp("read data", exp_q.pop_front(), mgmt_rdata_q);
    end
  end

  initial begin
    idle(20000);
    failures++;
    stop_test();
  end

  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_addr = 5'h00;
    mgmt_wdata = 16'h0000;
    idle(3);
    resetn <= 1'b1;
    cmp("adv_tx", 16'h01e1, adv_tx_q);
    rd(ADDR_ADVERTISE, 16'h01e1, 1'b1);
    rd(ADDR_PARTNER, 16'h0000, 1'b1);
    wr(ADDR_ADVERTISE, 16'he7ff);
    rd(ADDR_ADVERTISE, 16'h25ff, 1'b1);
    cmp("adv_tx", 16'h25ff, adv_tx_q);
    for (int i = 0; i < 6; i++) begin
      w = rnd() & 16'he7ff;
      wr(ADDR_ADVERTISE, w);
      rd(ADDR_ADVERTISE, w & 16'h25ff, 1'b1);
    end
    // With the enable low, neither a write nor a read may take effect.
    @(posedge clk);
    clk_en <= 1'b0;
    wr(ADDR_ADVERTISE, 16'h0000);
    rd(ADDR_ADVERTISE, 16'h0000, 1'b0);
    clk_en <= 1'b1;
    rd(ADDR_ADVERTISE, w & 16'h25ff, 1'b1);
    wr(ADDR_PARTNER, 16'hffff);
    rd(ADDR_PARTNER, 16'h0000, 1'b1);
    rd(5'h07, 16'h0000, 1'b0);
    p.ack(1'b1);
    idle(2);
    rd(ADDR_ADVERTISE, (w & 16'h25ff) | 16'h4000, 1'b1);
    p.send(16'hffff, M, 0);
    idle(5);
    cmp("updates", 16'h0001, 16'(n_upd));
    rd(ADDR_PARTNER, 16'he7ff, 1'b1);
    cmp("fault latch", 16'h0001, {15'h0000, rf_q});
    rd(ADDR_BASIC_STATUS, 16'h0000, 1'b0);
    idle(2);
    cmp("fault latch", 16'h0001, {15'h0000, rf_q});
    // A broken run of copies must not load anything.
    p.send(16'h0421, M - 1, 2);
    p.send(16'hcc21, 1, 0);
    idle(5);
    cmp("updates", 16'h0001, 16'(n_upd));
    p.send(16'hcc21, M, 1);
    idle(5);
    cmp("updates", 16'h0002, 16'(n_upd));
    rd(ADDR_PARTNER, 16'hc421, 1'b1);
    cmp("partner", 16'hc421, partner_q);
    cmp("fault latch", 16'h0001, {15'h0000, rf_q});
    rd(ADDR_BASIC_STATUS, 16'h0000, 1'b0);
    idle(2);
    cmp("fault latch", 16'h0000, {15'h0000, rf_q});
    p.ack(1'b0);
    idle(3);
    resetn <= 1'b0;
    idle(2);
    cmp("adv_tx", 16'h01e1, adv_tx_q);
    cmp("partner", 16'h0000, partner_q);
    resetn <= 1'b1;
    rd(ADDR_ADVERTISE, 16'h01e1, 1'b1);
    rd(ADDR_PARTNER, 16'h0000, 1'b1);
    idle(4);
    cmp("pending reads", 16'(exp_q.size()), 16'h0000);
    stop_test();
  end
endmodule
